//--- include/smt_pkg.sv
// package for the serial peripheral transaction engine
// assumes a 125 MHz core clock and a 32-bit AXI4-Lite register bus
`default_nettype none
package smt_pkg;
	// ****************************************************************
	// clock and timing
	// ****************************************************************
	localparam int CLK_KHZ     = 125000;
	localparam int TIMEOUT_US  = 1000;
	localparam int TIMEOUT_CYC = TIMEOUT_US * (CLK_KHZ / 1000);
	localparam int DIV_BASE    = 8;     // core cycles per half bit at rate 0

	// ****************************************************************
	// register map: printed index, byte address is four times it
	// ****************************************************************
	localparam logic [7:0] IDX_CTRL  = 8'h10;
	localparam logic [7:0] IDX_CMD   = 8'h11;
	localparam logic [7:0] IDX_DAT   = 8'h12;
	localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
	localparam logic [7:0] ADDR_CMD  = {IDX_CMD[5:0], 2'b00};
	localparam logic [7:0] ADDR_DAT  = {IDX_DAT[5:0], 2'b00};

	// ****************************************************************
	// control register fields above the configuration half-word
	// ****************************************************************
	localparam int CTRL_REQ_BIT = 16;
	localparam int CTRL_ACT_BIT = 17;
	localparam int CTRL_OVL_BIT = 18;
	localparam int CTRL_TMO_BIT = 19;
	localparam logic [2:0] BC_MAX = 3'h4;

	// configuration half-word, bits 15:0 of the control register
	typedef struct packed {
		logic [2:0] rate_sel;
		logic       clock_polarity;
		logic       clock_phase;
		logic [2:0] byte_count;
		logic       rx_en;
		logic [1:0] in_sel;
		logic [4:0] cs_en;
	} smt_cfg_t;

	localparam smt_cfg_t    CFG_RST = '0;
	localparam logic [15:0] CMD_RST = 16'h0000;
	localparam logic [23:0] DAT_RST = 24'h000000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_SETUP = 4'b0010,
		ST_RUN   = 4'b0100,
		ST_HOLD  = 4'b1000
	} smt_state_t;
endpackage
`default_nettype wire

//--- rtl/smt_spi_master.sv
// master-mode serial peripheral transaction engine with AXI4-Lite regs
// assumes an AXI4-Lite master on CORE_CLK and slaves on the serial pins
//
// What this block does
// - busy bit is high throughout a transaction and clears itself after.
// - request while busy sets overlap error, held until software clears.
// - timeout sets a sticky flag held until software clears it.
// - command register: 16 bits, opcode high byte, address low byte.
// - command bits go out MSB first, then payload bytes follow.
// - payload is 24 bits, LSB aligned, 1/2/3 bytes use low bytes.
// - write sends 1..5 bytes total, per byte count 0..4.
// - any opcode is sent unchecked.
// - read: received bytes land in the payload register automatically.
// - read sends two command bytes, receives 1..3, count 2..4.
// - polarity and phase bits choose among all four waveform modes.
// - mode 0: clock idles low, first bit out at select fall.
// - mode 3: clock idles high, data valid after first falling edge.
// - modes 0/3 capture on rising; modes 1/2 capture on falling.
// - request launches with current settings, clears when done.
// - byte count is zero based: bytes sent is count plus one, at most five.
// - mode n maps to polarity n[1], phase n[0].
// - every enabled chip select is asserted together.
//
// The AXI4-Lite register port is this design's own decision.
`default_nettype none
module smt_spi_master
	import smt_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
	input  wire logic        CORE_CLK,
	input  wire logic        ARST_N,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	input  wire logic [3:0]  SERIAL_IN,
	output logic             SERIAL_CLOCK_OUT,
	output logic             SERIAL_DATA_OUT,
	output logic [4:0]       CHIP_SELECT_N
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	smt_state_t  state_r;
	smt_cfg_t    cfg_r;
	smt_cfg_t    run_r;
	smt_cfg_t    cfg_new;
	logic [15:0] cmd_r;
	logic [23:0] dat_r;
	logic        ovl_r;
	logic        tmo_r;
	logic [39:0] sh_r;
	logic [39:0] frame;
	logic        cap_r;
	logic [6:0]  edge_r;
	logic [6:0]  last_edge;
	logic [10:0] div_r;
	logic [10:0] div_lim;
	logic        tick;
	logic [31:0] tmo_cnt_r;
	logic        tmo_hit;
	logic        done;
	logic [3:0]  si_m_r;
	logic [3:0]  si_s_r;
	logic        si_bit;
	logic        busy;
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        aw_hold_r;
	logic        w_hold_r;
	logic        wr_go;
	logic        wr_ctrl;
	logic        wr_req;
	logic        start;
	logic [31:0] rd_val;
	logic        rd_hit;
	logic [2:0]  bc;

	assign busy = (state_r != ST_IDLE);

	// ****************************************************************
	// serial input synchroniser, two flops per lane
	// ****************************************************************
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			si_m_r <= 4'h0;
			si_s_r <= 4'h0;
		end
		else
		begin
			si_m_r <= SERIAL_IN;
			si_s_r <= si_m_r;
		end
	end

	assign si_bit = si_s_r[run_r.in_sel];

	// ****************************************************************
	// register write decode and request handling
	// ****************************************************************
	assign wr_go   = aw_hold_r & w_hold_r & ~S_AXI_BVALID;
	assign wr_ctrl = wr_go & (aw_addr_r == ADDR_CTRL);
	assign wr_req  = wr_ctrl & w_strb_r[2] & w_data_r[CTRL_REQ_BIT];
	assign start   = wr_req & ~busy;
	assign done    = (state_r == ST_HOLD && tick) || tmo_hit;

	// merged configuration so a request sees settings of the same write
	always_comb
	begin
		cfg_new = cfg_r;
		if (wr_ctrl && w_strb_r[0])
			cfg_new[7:0] = w_data_r[7:0];
		if (wr_ctrl && w_strb_r[1])
			cfg_new[15:8] = w_data_r[15:8];
	end

	// clamp byte count to the documented maximum of five bytes
	assign bc = (run_r.byte_count > BC_MAX) ? BC_MAX : run_r.byte_count;

	// outgoing frame left aligned: command first, then low payload bytes
	always_comb
	begin
		unique case ((cfg_new.byte_count > BC_MAX) ? BC_MAX
			: cfg_new.byte_count)
			3'h0:    frame = {cmd_r[15:8], 32'h0};
			3'h1:    frame = {cmd_r, 24'h0};
			3'h2:    frame = {cmd_r, dat_r[7:0], 16'h0};
			3'h3:    frame = {cmd_r, dat_r[15:0], 8'h0};
			default: frame = {cmd_r, dat_r};
		endcase
	end

	// sixteen clock edges per byte, zero based count
	assign last_edge = 7'({bc, 4'h0} + 7'd15);

	// ****************************************************************
	// software registers and sticky flags
	// ****************************************************************
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			cfg_r <= CFG_RST;
			cmd_r <= CMD_RST;
		end
		else if (wr_go)
		begin
			cfg_r <= cfg_new;
			if (aw_addr_r == ADDR_CMD)
			begin
				if (w_strb_r[0]) cmd_r[7:0] <= w_data_r[7:0];
				if (w_strb_r[1]) cmd_r[15:8] <= w_data_r[15:8];
			end
		end
	end

	// payload: hardware capture of a read wins over a software write
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			dat_r <= DAT_RST;
		else if (done && !tmo_hit && run_r.rx_en && bc >= 3'h2)
		begin
			unique case (bc)
				3'h2:    dat_r <= {16'h0, sh_r[7:0]};
				3'h3:    dat_r <= {8'h0, sh_r[15:0]};
				default: dat_r <= sh_r[23:0];
			endcase
		end
		else if (wr_go && aw_addr_r == ADDR_DAT)
		begin
			if (w_strb_r[0]) dat_r[7:0] <= w_data_r[7:0];
			if (w_strb_r[1]) dat_r[15:8] <= w_data_r[15:8];
			if (w_strb_r[2]) dat_r[23:16] <= w_data_r[23:16];
		end
	end

	// error flags: write one to clear, a new event wins over the clear
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			ovl_r <= 1'b0;
			tmo_r <= 1'b0;
		end
		else
		begin
			if (wr_req && busy)
				ovl_r <= 1'b1;
			else if (wr_ctrl && w_strb_r[2] && w_data_r[CTRL_OVL_BIT])
				ovl_r <= 1'b0;
			if (tmo_hit)
				tmo_r <= 1'b1;
			else if (wr_ctrl && w_strb_r[2] && w_data_r[CTRL_TMO_BIT])
				tmo_r <= 1'b0;
		end
	end

	// ****************************************************************
	// half-bit rate divider and transaction timeout
	// ****************************************************************
	assign div_lim = 11'((DIV_BASE << run_r.rate_sel) - 1);
	assign tick    = busy && (div_r == div_lim);

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			div_r <= 11'h0;
		else if (!busy || tick)
			div_r <= 11'h0;
		else
			div_r <= div_r + 11'h1;
	end

	assign tmo_hit = busy && (tmo_cnt_r == 32'(TIMEOUT_CYCLES - 1));

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			tmo_cnt_r <= 32'h0;
		else if (!busy)
			tmo_cnt_r <= 32'h0;
		else
			tmo_cnt_r <= tmo_cnt_r + 32'h1;
	end

	// ****************************************************************
	// serial engine
	// ****************************************************************
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			state_r          <= ST_IDLE;
			run_r            <= CFG_RST;
			sh_r             <= 40'h0;
			cap_r            <= 1'b0;
			edge_r           <= 7'h0;
			SERIAL_CLOCK_OUT <= 1'b0;
			SERIAL_DATA_OUT  <= 1'b0;
			CHIP_SELECT_N    <= 5'h1f;
		end
		else if (start)
		begin
			state_r          <= ST_SETUP;
			run_r            <= cfg_new;
			sh_r             <= frame;
			edge_r           <= 7'h0;
			CHIP_SELECT_N    <= ~cfg_new.cs_en;
			SERIAL_CLOCK_OUT <= cfg_new.clock_polarity;
			// phase 0 drives the first bit with the select edge
			SERIAL_DATA_OUT  <= cfg_new.clock_phase ? 1'b0
				: frame[39];
		end
		else if (done)
		begin
			state_r          <= ST_IDLE;
			CHIP_SELECT_N    <= 5'h1f;
			SERIAL_CLOCK_OUT <= run_r.clock_polarity;
		end
		else if (!busy)
		begin
			// idle clock follows the programmed polarity, so a mode change
			// written ahead of the request settles the clock level well before its select edge
			SERIAL_CLOCK_OUT <= cfg_r.clock_polarity;
		end
		else if (tick)
		begin
			unique case (state_r)
				ST_SETUP: state_r <= ST_RUN;
				ST_RUN:
				begin
					SERIAL_CLOCK_OUT <= ~SERIAL_CLOCK_OUT;
					edge_r <= edge_r + 7'h1;
					if (edge_r == last_edge)
						state_r <= ST_HOLD;
					if (!edge_r[0])
					begin
						// leading edge: capture for phase 0, launch for 1
						if (!run_r.clock_phase)
							cap_r <= si_bit;
						else
							SERIAL_DATA_OUT <= sh_r[39];
					end
					else if (!run_r.clock_phase)
					begin
						sh_r <= {sh_r[38:0], cap_r};
						SERIAL_DATA_OUT <= sh_r[38];
					end
					else
						sh_r <= {sh_r[38:0], si_bit};
				end
				default: state_r <= state_r;
			endcase
		end
	end

	// ****************************************************************
	// AXI4-Lite write channels
	// ****************************************************************
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			aw_hold_r     <= 1'b0;
			w_hold_r      <= 1'b0;
			aw_addr_r     <= 8'h0;
			w_data_r      <= 32'h0;
			w_strb_r      <= 4'h0;
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY  <= 1'b1;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= RESP_OKAY;
		end
		else
		begin
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_hold_r     <= 1'b1;
				aw_addr_r     <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_hold_r     <= 1'b1;
				w_data_r     <= S_AXI_WDATA;
				w_strb_r     <= S_AXI_WSTRB;
				S_AXI_WREADY <= 1'b0;
			end
			if (wr_go)
			begin
				aw_hold_r    <= 1'b0;
				w_hold_r     <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= (aw_addr_r == ADDR_CTRL ||
					aw_addr_r == ADDR_CMD || aw_addr_r == ADDR_DAT)
					? RESP_OKAY : RESP_SLVERR;
			end
			if (S_AXI_BVALID && S_AXI_BREADY)
			begin
				S_AXI_BVALID  <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY  <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite read channels
	// ****************************************************************
	always_comb
	begin
		rd_hit = 1'b1;
		unique case (S_AXI_ARADDR)
			ADDR_CTRL: rd_val = {12'h0, tmo_r, ovl_r, busy, busy, cfg_r};
			ADDR_CMD:  rd_val = {16'h0, cmd_r};
			ADDR_DAT:  rd_val = {8'h0, dat_r};
			default:
			begin
				rd_val = 32'h0;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0;
			S_AXI_RRESP   <= RESP_OKAY;
		end
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b1;
			S_AXI_RDATA   <= rd_val;
			S_AXI_RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_AXI_RVALID && S_AXI_RREADY)
		begin
			S_AXI_RVALID  <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

endmodule
`default_nettype wire

//--- sim/smt_spi_master_assertions.sv
// checker for the engine's bus handshakes and serial pins
// assumes binding to smt_spi_master, single core clock domain
`default_nettype none
module smt_spi_master_chk
(
	input wire logic       CORE_CLK,
	input wire logic       ARST_N,
	input wire logic       S_AXI_AWVALID,
	input wire logic       S_AXI_AWREADY,
	input wire logic       S_AXI_WVALID,
	input wire logic       S_AXI_WREADY,
	input wire logic       S_AXI_BVALID,
	input wire logic       S_AXI_BREADY,
	input wire logic       S_AXI_ARVALID,
	input wire logic       S_AXI_ARREADY,
	input wire logic       S_AXI_RVALID,
	input wire logic       S_AXI_RREADY,
	input wire logic       SERIAL_CLOCK_OUT,
	input wire logic       SERIAL_DATA_OUT,
	input wire logic [4:0] CHIP_SELECT_N
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dcb @(posedge CORE_CLK);
	endclocking
	default disable iff (!ARST_N);
	logic sel;
	// any select low means a frame is on the wire
	assign sel = ~&CHIP_SELECT_N;
	// at rate 0 a half bit is eight core cycles, slower rates longer
	sequence s_quiet;
		$stable(SERIAL_CLOCK_OUT) [*7];
	endsequence
	a_setup_quiet:
		assert property ($rose(sel) |=> s_quiet)
		else $error("serial clock moved inside select setup");
	a_half_bit:
		assert property ($changed(SERIAL_CLOCK_OUT) |=> s_quiet)
		else $error("serial clock half bit too short");
	a_data_launch:
		assert property (sel && !$rose(sel) && $changed(SERIAL_DATA_OUT)
			|-> $changed(SERIAL_CLOCK_OUT))
		else $error("data out changed away from a clock edge");
	a_select_steady:
		assert property (sel && $past(sel) |-> $stable(CHIP_SELECT_N))
		else $error("selects changed inside a frame");
	a_start_on_write:
		assert property ($rose(sel) |-> $rose(S_AXI_BVALID))
		else $error("frame started without a register write");
	a_write_answer:
		assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
			&& S_AXI_WREADY |=> !S_AXI_AWREADY && !S_AXI_WREADY
			##1 S_AXI_BVALID)
		else $error("write response late");
	a_write_done:
		assert property (S_AXI_BVALID && S_AXI_BREADY
			|=> S_AXI_AWREADY && S_AXI_WREADY && !S_AXI_BVALID)
		else $error("write channel not freed");
	a_read_answer:
		assert property (S_AXI_ARVALID && S_AXI_ARREADY
			|=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read data late");
	a_read_done:
		assert property (S_AXI_RVALID && S_AXI_RREADY
			|=> S_AXI_ARREADY && !S_AXI_RVALID)
		else $error("read channel not freed");
endmodule
bind smt_spi_master smt_spi_master_chk smt_spi_master_chk_inst (
	.CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.SERIAL_CLOCK_OUT(SERIAL_CLOCK_OUT),
	.SERIAL_DATA_OUT(SERIAL_DATA_OUT), .CHIP_SELECT_N(CHIP_SELECT_N));
`default_nettype wire

//--- sim/smt_slave_model.sv
// behavioural serial slave on the shared clock and data lines
// assumes the bench sets polarity, phase and reply while selects are high
`default_nettype none
module smt_slave_model
(
	input wire logic        sclk,
	input wire logic        sdo,
	input wire logic        sel_n,
	input wire logic        cpol,
	input wire logic        cpha,
	input wire logic [39:0] rep,
	output logic            si,
	output logic [39:0]     cap,
	output logic [7:0]      ncap
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [39:0] sh;
	initial
	begin
		si = 1'b0;
		cap = '0;
		ncap = '0;
		sh = '0;
	end
	// phase 0 puts the first reply bit out as soon as selected
	always @(negedge sel_n)
	begin
		sh = rep;
		cap = '0;
		ncap = '0;
		if (!cpha)
		begin
			si = sh[39];
			sh = sh << 1;
		end
	end
	// released line shows the inverse of its last bit
	always @(posedge sel_n)
		si = ~si;
	// capture on one edge kind, launch the next reply bit on the other
	always @(sclk)
		if (!sel_n)
		begin
			if ((sclk != cpol) ^ cpha)
			begin
				cap = {cap[38:0], sdo};
				ncap = ncap + 8'h01;
			end
			else
			begin
				si = sh[39];
				sh = sh << 1;
			end
		end
endmodule
`default_nettype wire

//--- sim/smt_spi_master_tb.sv
// self-checking bench for the serial transaction engine
// assumes the slave model and the bound checker are compiled before it
`default_nettype none
module smt_spi_master_tb
	import smt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TMO = 2000;
	logic        clk = 0;
	logic        rst_n = 0;
	logic [7:0]  awaddr = 0;
	logic [7:0]  araddr = 0;
	logic        awvalid = 0;
	logic        wvalid = 0;
	logic        bready = 0;
	logic        arvalid = 0;
	logic        rready = 0;
	logic [31:0] wdata = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        sclk, sdo, si;
	logic [1:0]  bresp, rresp, rs;
	logic [1:0]  lane = 0;
	logic [31:0] rdata, rd;
	logic [4:0]  csn;
	logic [3:0]  sin;
	logic        cpol = 0;
	logic        cpha = 0;
	logic [39:0] rep = 0;
	logic [39:0] cap;
	logic [7:0]  ncap;
	int          miscompares = 0;
	int          cmp_count = 0;
	always #4 clk = ~clk;
	// selected lane carries the slave, the others its inverse
	assign sin = {4{~si}} ^ (4'h1 << lane);
	smt_spi_master #(.TIMEOUT_CYCLES(TMO)) smt_spi_master_inst (
		.CORE_CLK(clk), .ARST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SERIAL_IN(sin),
		.SERIAL_CLOCK_OUT(sclk), .SERIAL_DATA_OUT(sdo),
		.CHIP_SELECT_N(csn));
	smt_slave_model smt_slave_model_inst (
		.sclk(sclk), .sdo(sdo), .sel_n(&csn), .cpol(cpol), .cpha(cpha),
		.rep(rep), .si(si), .cap(cap), .ncap(ncap));
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic hang();
		miscompares++;
		give_verdict();
	endtask
	// write one word, each channel released once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		rs = bresp;
		if (i == 50) hang();
	endtask
	// read one word into rd and rs
	task automatic axr(input logic [7:0] a);
		int i;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		rd = rdata;
		rs = rresp;
		if (i == 50) hang();
	endtask
	// poll the busy bit until it clears, bounded
	task automatic wait_idle(input int n);
		int i;
		axr(ADDR_CTRL);
		for (i = 0; i < n && rd[17] !== 1'b0; i++)
			axr(ADDR_CTRL);
		if (rd[17] !== 1'b0) hang();
	endtask
	task automatic t_regs();
		axr(ADDR_CMD);
		chk(40'(rd), 40'h0);
		axw(ADDR_CMD, 32'hdead1234);
		axr(ADDR_CMD);
		chk(40'(rd), 40'h1234);
		axw(ADDR_DAT, 32'hffa5c3e7);
		axr(ADDR_DAT);
		chk(40'(rd), 40'ha5c3e7);
		axw(8'h4c, 32'h1);
		chk(40'(rs), 40'(RESP_SLVERR));
		axr(8'h4c);
		chk(40'({rs, rd}), 40'({RESP_SLVERR, 32'h0}));
		$display("register test done");
	endtask
	// one frame: mode m, count bc, receive rx, selects cs, reply r
	task automatic t_frame(input logic [1:0] m, input logic [2:0] bc,
		input logic rx, input logic [4:0] cs, input logic [15:0] cmd,
		input logic [23:0] dat, input logic [23:0] r);
		logic [39:0] e;
		logic [15:0] cfg;
		cfg = {3'h0, m, bc, rx, m, cs};
		cpol = m[1];
		cpha = m[0];
		lane <= m;
		rep = {16'hc3c3, 24'(r << (8 * (4 - bc)))};
		e = ({cmd, 24'h0} >> (8 * (4 - bc)))
			| (bc > 1 ? 40'(dat) & ((40'h1 << (8 * (bc - 1))) - 1) : 40'h0);
		axw(ADDR_CTRL, {16'h0, cfg});
		axw(ADDR_CMD, 32'(cmd));
		axw(ADDR_DAT, 32'(dat));
		axw(ADDR_CTRL, {15'h0, 1'b1, cfg});
		chk(40'(csn), {35'h0, ~cs});
		axr(ADDR_CTRL);
		chk(40'(rd[17:16]), 40'h3);
		wait_idle(400);
		chk(40'(rd[17:16]), 40'h0);
		chk(40'(ncap), 40'(8 * (bc + 1)));
		chk(rx ? cap >> (8 * (bc - 1)) : cap, rx ? 40'(cmd) : e);
		chk(40'(sclk), 40'(m[1]));
		axr(ADDR_DAT);
		e = rx ? 40'(r) & ((40'h1 << (8 * (bc - 1))) - 1) : 40'(dat);
		chk(40'(rd), e);
		$display("frame mode %0d count %0d done", m, bc);
	endtask
	// slow frame runs into the timeout, second request overlaps it
	task automatic t_timeout();
		cpol = 1'b0;
		cpha = 1'b0;
		axw(ADDR_CTRL, 32'h0);
		axw(ADDR_DAT, 32'h5a5a5a);
		axw(ADDR_CTRL, {15'h0, 1'b1, 3'h3, 2'h0, 3'h4, 1'b1, 2'h0, 5'h08});
		axw(ADDR_CTRL, {15'h0, 1'b1, 3'h3, 2'h0, 3'h4, 1'b1, 2'h0, 5'h08});
		wait_idle(1000);
		chk(40'(rd[19:16]), 40'hc);
		chk(40'(csn), 40'h1f);
		axr(ADDR_DAT);
		chk(40'(rd), 40'h5a5a5a);
		axw(ADDR_CTRL, 32'h000c0000);
		axr(ADDR_CTRL);
		chk(40'(rd[19:16]), 40'h0);
		$display("timeout test done");
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_frame(2'h0, 3'h0, 1'b0, 5'h01, 16'h02a5, 24'h0, 24'h0);
		t_frame(2'h1, 3'h2, 1'b1, 5'h06, 16'h0311, 24'h0, 24'h00005a);
		t_frame(2'h2, 3'h3, 1'b1, 5'h10, 16'h9c3e, 24'h0, 24'h00b4e1);
		t_frame(2'h3, 3'h4, 1'b0, 5'h1f, 16'h0280, 24'h81c3e7, 24'h0);
		t_frame(2'h0, 3'h4, 1'b1, 5'h03, 16'h0340, 24'h0, 24'h7e1d2c);
		t_frame(2'h3, 3'h1, 1'b0, 5'h08, 16'h77f0, 24'h0, 24'h0);
		t_timeout();
		give_verdict();
	end
endmodule
`default_nettype wire
